// >>> logic/ishc_top.sv
// Purpose: Interrupt posting, stacking, request line and orderly halt
// Assumes: Engine status inputs are synchronous to clk
// Notes:   Status reads clear only the bits that were returned
`timescale 1ns/1ps

// Contract
// R1: While a pending flag is set, new conditions go into the hidden level.
// R2: With both levels full, further conditions add bits to the hidden level.
// R3: Clearing read drops request for a gap, promotes stacked bits, reasserts.
// R4: Masked non-fatal posts status only; no flag, no request, no stacking.
// R5: After masked non-fatal, later conditions post directly; old bit stays.
// R6: Simultaneous conditions before a flag is set all post to first level.
// R7: After DMA condition, SCSI posting waits for empty DMA FIFO.
// R8: Host clears or flushes FIFOs after DMA condition when FIFO not empty.
// R9: Fetch in progress completes unless faulted; fetched instruction not run.
// R10: SCSI condition during memory write flushes DMA FIFO; else bus cycle only.
// R11: Finish begun REQ/ACK handshake and outstanding synchronous offset first.
// R12: A started transfer-control instruction runs to completion before halt.
// R13: Phase-conditional jump or call loads its target into script pointer.
// R14: Host reads summary first, then the status register flagged pending.
// R15: Both pending: one 16-bit read, or byte reads ten clocks apart.
// R16: Host services both classes, DMA before SCSI.
// R17: Polling host re-reads summary before leaving its routine.
// R18: Masked fatal still halts and sets flag, but request stays off.
// R19: Only arbitration-done, selected, and target attention are non-fatal.
// R20: DMA FIFO empty bit is pure status, never interrupts, never cleared.
// R21: Clearing an enable after request assertion does not drop request.
// R22: Request gap before presenting stacked conditions is configurable.
module ishc_top
  import ishc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rstn,
  input  wire logic [ishc_pkg::AW-1:0] avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [3:0]           avs_byteenable,
  input  wire logic [31:0]          avs_writedata,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [ishc_pkg::SW-1:0] scsi_cond_in,
  input  wire logic [ishc_pkg::DW-1:0] dma_cond_in,
  input  wire logic                 dma_fifo_empty,
  input  wire logic                 dma_dir_write,
  input  wire logic                 fetch_active,
  input  wire logic                 fetch_fault,
  input  wire logic                 bus_cycle_active,
  input  wire logic                 reqack_busy,
  input  wire logic                 sync_offset_pending,
  input  wire logic                 xfer_ctrl_exec,
  input  wire logic                 phase_jump,
  input  wire logic [31:0]          jump_target,
  input  wire logic                 engine_start,
  output logic                      irq_n,
  output logic                      engine_halt_req,
  output logic                      engine_halted,
  output logic                      dma_flush_req,
  output logic                      clear_fifos_pulse,
  output logic                      flush_fifo_pulse,
  output logic                      ptr_load,
  output logic      [31:0]          ptr_value
);
  import ishc_pkg::*;

  logic [SW-1:0] scsi_int_enable_reg;
  logic [DW-1:0] dma_int_enable_reg;
  logic          tgt_mode;
  logic [7:0]    gap_cfg;
  logic [7:0]    gap_cnt;
  logic          gap_busy;
  logic          gap_start;
  logic          promote;
  logic          stack;
  logic          lock;
  logic [SW-1:0] held;
  logic [SW-1:0] s_ev;
  logic [SW-1:0] gen_s;
  logic [SW-1:0] first_s;
  logic [DW-1:0] first_d;
  logic          scsi_pending_flag;
  logic          dma_pending_flag;
  logic          stk_s;
  logic          stk_d;
  logic          raise_s;
  logic          raise_d;
  logic          req;
  logic          acc;
  logic          cap;
  logic [31:0]   next_rdata;
  logic [SW-1:0] snap_s;
  logic [DW-1:0] snap_d;
  logic          snap_ps;
  logic          snap_pd;
  logic [SW-1:0] clr_s;
  logic [DW-1:0] clr_d;
  logic          clr_ps;
  logic          clr_pd;
  logic          wr_ctrl;
  logic          trig;
  logic          trig_scsi;
  logic          drain_ok;
  logic          flush_mode;
  ishc_halt_t    st;
  ishc_halt_t    next_st;

  // ==========================================================
  // Avalon slave: one wait cycle, data ready when waitrequest drops
  assign req = avs_read | avs_write;
  assign acc = req & !avs_waitrequest;
  assign cap = avs_read & avs_waitrequest;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !(req && avs_waitrequest);
    end
  end

  always_comb begin
    next_rdata = 32'h0;
    case (avs_address)
      REG_SUMMARY: begin
        next_rdata[SUM_SCSI] = scsi_pending_flag;
        next_rdata[SUM_DMA]  = dma_pending_flag;
        next_rdata[SUM_IRQ]  = !irq_n;
        next_rdata[SUM_HALT] = engine_halted;
      end
      REG_STATUS: begin
        next_rdata[SW-1:0]                = first_s;
        next_rdata[STAT_DMA +: DW]        = first_d;
        next_rdata[STAT_DFE]              = dma_fifo_empty; // [R20]
      end
      REG_ENABLE: begin
        next_rdata[SW-1:0]         = scsi_int_enable_reg;
        next_rdata[STAT_DMA +: DW] = dma_int_enable_reg;
      end
      REG_CTRL: begin
        next_rdata[CTRL_TGT]     = tgt_mode;
        next_rdata[CTRL_GAP +: 8] = gap_cfg;
      end
      default: begin
        next_rdata = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0;
    end else if (cap) begin
      avs_readdata <= next_rdata;
    end
  end

  // Snapshot what was returned so late arrivals are not wiped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snap_s  <= '0;
      snap_d  <= '0;
      snap_ps <= 1'b0;
      snap_pd <= 1'b0;
    end else if (cap) begin
      if (avs_address == REG_STATUS && avs_byteenable[0]) begin
        snap_s  <= first_s;
        snap_ps <= scsi_pending_flag;
      end else begin
        snap_s  <= '0;
        snap_ps <= 1'b0;
      end
      if (avs_address == REG_STATUS && avs_byteenable[1]) begin
        snap_d  <= first_d;
        snap_pd <= dma_pending_flag;
      end else begin
        snap_d  <= '0;
        snap_pd <= 1'b0;
      end
    end
  end

  assign clr_s  = (acc && avs_read) ? snap_s : '0;
  assign clr_d  = (acc && avs_read) ? snap_d : '0;
  assign clr_ps = acc & avs_read & snap_ps;
  assign clr_pd = acc & avs_read & snap_pd;

  // ==========================================================
  // Software-written registers
  assign wr_ctrl = acc & avs_write & (avs_address == REG_CTRL);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scsi_int_enable_reg <= SCSI_EN_RST;
      dma_int_enable_reg  <= DMA_EN_RST;
    end else if (acc && avs_write && avs_address == REG_ENABLE) begin
      if (avs_byteenable[0]) begin
        scsi_int_enable_reg <= avs_writedata[SW-1:0];
      end
      if (avs_byteenable[1]) begin
        dma_int_enable_reg <= avs_writedata[STAT_DMA +: DW];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tgt_mode <= 1'b0;
      gap_cfg  <= GAP_CLKS_RST;
    end else if (wr_ctrl) begin
      if (avs_byteenable[0]) begin
        tgt_mode <= avs_writedata[CTRL_TGT];
      end
      if (avs_byteenable[1]) begin
        gap_cfg <= avs_writedata[CTRL_GAP +: 8]; // [R22]
      end
    end
  end

  // FIFO commands are self-clearing strobes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clear_fifos_pulse <= 1'b0;
      flush_fifo_pulse  <= 1'b0;
    end else begin
      clear_fifos_pulse <= wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_CLF]; // [R8]
      flush_fifo_pulse  <= wr_ctrl & avs_byteenable[0] & avs_writedata[CTRL_FLF]; // [R8]
    end
  end

  // ==========================================================
  // SCSI lockout until the DMA FIFO drains
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock <= 1'b0;
      held <= '0;
    end else begin
      lock <= (lock | (|dma_cond_in)) & !dma_fifo_empty; // [R7]
      held <= lock ? (held | scsi_cond_in) : '0; // [R7]
    end
  end

  assign s_ev  = lock ? '0 : (held | scsi_cond_in);
  assign gen_s = scsi_int_enable_reg | ~(tgt_mode ? NONFATAL_TGT : NONFATAL_INIT); // [R19]
  assign stack = scsi_pending_flag | dma_pending_flag | gap_busy; // [R1]

  // ==========================================================
  // Stack levels
  ishc_stack_level #(.W(SW)) u_scsi (
    .clk      (clk),
    .rstn     (rstn),
    .ev       (s_ev),
    .gen      (gen_s),
    .en       (scsi_int_enable_reg),
    .stack    (stack),
    .clr      (clr_s),
    .clr_pend (clr_ps),
    .promote  (promote),
    .first    (first_s),
    .pend     (scsi_pending_flag),
    .stacked  (stk_s),
    .raise    (raise_s)
  );

  // Every DMA condition is fatal, so all bits generate the flag
  ishc_stack_level #(.W(DW)) u_dma (
    .clk      (clk),
    .rstn     (rstn),
    .ev       (dma_cond_in),
    .gen      ({DW{1'b1}}),
    .en       (dma_int_enable_reg),
    .stack    (stack),
    .clr      (clr_d),
    .clr_pend (clr_pd),
    .promote  (promote),
    .first    (first_d),
    .pend     (dma_pending_flag),
    .stacked  (stk_d),
    .raise    (raise_d)
  );

  // ==========================================================
  // Request gap and promotion
  assign gap_start = (clr_ps | clr_pd) & (stk_s | stk_d) & !gap_busy; // [R3]
  assign promote   = gap_busy & (gap_cnt <= 8'h01);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap_busy <= 1'b0;
      gap_cnt  <= 8'h00;
    end else if (gap_start) begin
      gap_busy <= 1'b1;
      gap_cnt  <= gap_cfg; // [R22]
    end else if (promote) begin
      gap_busy <= 1'b0;
      gap_cnt  <= 8'h00;
    end else if (gap_busy) begin
      gap_cnt <= gap_cnt - 8'h01;
    end
  end

  // Enable changes never drop an asserted request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n <= 1'b1;
    end else if (gap_start || (gap_busy && !promote)) begin
      irq_n <= 1'b1; // [R3]
    end else if (raise_s || raise_d) begin
      irq_n <= 1'b0; // [R18]
    end else if (!scsi_pending_flag && !dma_pending_flag) begin
      irq_n <= 1'b1; // [R21]
    end
  end

  // ==========================================================
  // Orderly halt
  assign trig_scsi = |(s_ev & gen_s);
  assign trig      = trig_scsi | (|dma_cond_in); // [R18] [R19]
  assign drain_ok  = (!fetch_active || fetch_fault) // [R9]
                   && !bus_cycle_active // [R10]
                   && !reqack_busy && !sync_offset_pending // [R11]
                   && !xfer_ctrl_exec // [R12]
                   && (!flush_mode || dma_fifo_empty); // [R10]

  always_comb begin
    next_st = st;
    case (st)
      HS_RUN: begin
        if (trig) begin
          next_st = HS_DRAIN;
        end
      end
      HS_DRAIN: begin
        if (drain_ok) begin
          next_st = HS_HALT;
        end
      end
      HS_HALT: begin
        if (engine_start) begin
          next_st = HS_RUN;
        end
      end
      default: begin
        next_st = HS_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st              <= HS_RUN;
      engine_halt_req <= 1'b0;
      engine_halted   <= 1'b0;
    end else begin
      st              <= next_st;
      engine_halt_req <= next_st != HS_RUN; // [R9]
      engine_halted   <= next_st == HS_HALT;
    end
  end

  // Memory-write direction with SCSI cause keeps the FIFO draining
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flush_mode    <= 1'b0;
      dma_flush_req <= 1'b0;
    end else if (st == HS_RUN && trig) begin
      flush_mode    <= trig_scsi & dma_dir_write; // [R10]
      dma_flush_req <= trig_scsi & dma_dir_write & !dma_fifo_empty;
    end else if (st == HS_DRAIN) begin
      dma_flush_req <= flush_mode & !dma_fifo_empty & !drain_ok;
    end else begin
      flush_mode    <= 1'b0;
      dma_flush_req <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_load  <= 1'b0;
      ptr_value <= 32'h0;
    end else begin
      ptr_load <= (st == HS_DRAIN) && drain_ok && phase_jump; // [R13]
      if ((st == HS_DRAIN) && drain_ok && phase_jump) begin
        ptr_value <= jump_target; // [R13]
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence drain_exit_s;
    (st == HS_DRAIN) && drain_ok;
  endsequence

  gap_then_promote_a: assert property (gap_start |=> irq_n ##[0:256] promote) // [R3]
    else $error("stacked conditions not promoted after gap");

  gap_line_off_a: assert property (gap_busy && !promote |-> irq_n) // [R3]
    else $error("request asserted during gap");

  irq_hold_a: assert property ((!irq_n && !gap_start && (scsi_pending_flag || dma_pending_flag))
    |=> !irq_n) // [R21]
    else $error("request dropped while pending");

  masked_fatal_a: assert property ((st == HS_RUN && !stack && irq_n && dma_cond_in != '0
    && (dma_cond_in & dma_int_enable_reg) == '0) |=> dma_pending_flag && irq_n && engine_halt_req) // [R18]
    else $error("masked fatal handling wrong");

  lockout_a: assert property ((lock && scsi_cond_in != '0) |=> held != '0 || !lock) // [R7]
    else $error("locked out condition lost");

  drain_wait_a: assert property ((st == HS_DRAIN && (reqack_busy || xfer_ctrl_exec
    || sync_offset_pending)) |=> !engine_halted) // [R11]
    else $error("halted before handshake done");

  flush_wait_a: assert property ((st == HS_DRAIN && flush_mode && !dma_fifo_empty)
    |=> !engine_halted) // [R10]
    else $error("halted before FIFO flush");

  jump_load_a: assert property ((drain_exit_s and phase_jump)
    |=> ptr_load && engine_halted && ptr_value == $past(jump_target)) // [R13]
    else $error("jump target not loaded");

  dfe_read_a: assert property ((cap && avs_address == REG_STATUS)
    |=> avs_readdata[STAT_DFE] == $past(dma_fifo_empty)) // [R20]
    else $error("fifo empty status wrong");

endmodule

// >>> logic/ishc_pkg.sv
// Purpose: Shared constants for the interrupt stack and halt control block
// Assumes: One 250 MHz clock, Avalon-MM register access, 32-bit words
// Notes:   Register offsets are byte addresses of aligned words
package ishc_pkg;

  // ==========================================================
  // Widths and clock
  localparam int SW     = 8;
  localparam int DW     = 7;
  localparam int AW     = 5;
  localparam int CLK_NS = 4;

  // ==========================================================
  // Register map
  localparam logic [AW-1:0] REG_SUMMARY = 5'h00;
  localparam logic [AW-1:0] REG_STATUS  = 5'h04;
  localparam logic [AW-1:0] REG_ENABLE  = 5'h08;
  localparam logic [AW-1:0] REG_CTRL    = 5'h0c;

  // ==========================================================
  // Field positions
  localparam int SUM_SCSI   = 0;
  localparam int SUM_DMA    = 1;
  localparam int SUM_IRQ    = 2;
  localparam int SUM_HALT   = 3;
  localparam int STAT_DMA   = 8;
  localparam int STAT_DFE   = 15;
  localparam int CTRL_CLF   = 0;
  localparam int CTRL_FLF   = 1;
  localparam int CTRL_TGT   = 2;
  localparam int CTRL_GAP   = 8;

  // ==========================================================
  // Condition codes and reset values
  localparam int ARB_DONE_BIT = 0;
  localparam int SELECTED_BIT = 1;
  localparam int ATTN_BIT     = 2;
  localparam logic [SW-1:0] NONFATAL_INIT = 8'h03;
  localparam logic [SW-1:0] NONFATAL_TGT  = 8'h07;
  localparam logic [SW-1:0] SCSI_EN_RST   = 8'h00;
  localparam logic [DW-1:0] DMA_EN_RST    = 7'h00;
  localparam logic [7:0]    GAP_CLKS_RST  = 8'h08;

  typedef enum logic [2:0] {
    HS_RUN   = 3'b001,
    HS_DRAIN = 3'b010,
    HS_HALT  = 3'b100
  } ishc_halt_t;

endpackage

// >>> logic/ishc_stack_level.sv
// Purpose: Two-level condition stack for one interrupt class
// Assumes: Events and controls come from logic on the same clock
// Notes:   Clear takes a bit mask so bits posted after a read survive
`timescale 1ns/1ps
module ishc_stack_level #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] ev,
  input  wire logic [W-1:0] gen,
  input  wire logic [W-1:0] en,
  input  wire logic         stack,
  input  wire logic [W-1:0] clr,
  input  wire logic         clr_pend,
  input  wire logic         promote,
  output logic      [W-1:0] first,
  output logic              pend,
  output logic              stacked,
  output logic              raise
);
  logic [W-1:0] second;
  logic         sgen;
  logic         sen;
  logic         hit_g;
  logic         hit_e;

  assign hit_g   = |(ev & gen);
  assign hit_e   = |(ev & en);
  assign stacked = |second;
  assign raise   = promote ? (sen | hit_e) : (!stack & hit_e);

  // ==========================================================
  // Visible level; set wins over a clearing read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first <= '0;
    end else if (promote) begin
      first <= (first & ~clr) | second | ev; // [R3]
    end else if (!stack) begin
      first <= (first & ~clr) | ev; // [R5] [R6]
    end else begin
      first <= first & ~clr;
    end
  end

  // Hidden level keeps accumulating while anything is pending
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      second <= '0;
      sgen   <= 1'b0;
      sen    <= 1'b0;
    end else if (promote) begin
      second <= '0;
      sgen   <= 1'b0;
      sen    <= 1'b0;
    end else if (stack) begin
      second <= second | ev; // [R1] [R2]
      sgen   <= sgen | hit_g;
      sen    <= sen | hit_e;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend <= 1'b0;
    end else if (promote) begin
      pend <= sgen | hit_g;
    end else if (clr_pend) begin
      pend <= !stack & hit_g;
    end else if (!stack && hit_g) begin
      pend <= 1'b1; // [R4]
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  stack_keeps_a: assert property ((stack && !promote && ev != '0) |=> (second & $past(ev)) == $past(ev)) // [R1]
    else $error("stacked event lost");

  masked_nostack_a: assert property ((!stack && !promote && !pend && !clr_pend && !hit_g && ev != '0)
    |=> !pend && first != '0) // [R4]
    else $error("masked non-fatal set pending");

endmodule

// >>> sim/ishc_host_model.sv
// Purpose: Host side model issuing register accesses
// Assumes: Avalon-MM master on the block clock
// Notes:   Waits without limit; the bench timeout cuts hangs
`timescale 1ns/1ps
module ishc_host_model (
  input  wire logic                    clk,
  input  wire logic                    avs_waitrequest,
  output logic [ishc_pkg::AW-1:0]      avs_address,
  output logic                         avs_read,
  output logic                         avs_write,
  output logic [3:0]                   avs_byteenable,
  output logic [31:0]                  avs_writedata
);
  import ishc_pkg::*;
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'h0;
    avs_writedata = 32'h0;
  end
  // ==========================================
  // One bus cycle, held until waitrequest low
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_byteenable <= be;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the interrupt stack and halt block
// Assumes: Host model drives the bus; bench drives engine and events
// Notes:   Gap register randomised so the gap timing is not one value
`timescale 1ns/1ps
module testbench;
  import ishc_pkg::*;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [AW-1:0]     avs_address;
  logic              avs_read, avs_write, avs_waitrequest;
  logic [3:0]        avs_byteenable;
  logic [31:0]       avs_writedata, avs_readdata, ptr_value;
  logic [SW-1:0]     scsi_cond_in = '0;
  logic [DW-1:0]     dma_cond_in = '0;
  logic              dma_fifo_empty = 1'b1;
  logic              fetch_active = 1'b0;
  logic              xfer_ctrl_exec = 1'b0;
  logic              phase_jump = 1'b0;
  logic              engine_start = 1'b0;
  logic              tie = 1'b0;
  logic              dir_wr = 1'b0;
  logic [31:0]       jump_target = 32'h0;
  logic              irq_n, engine_halt_req, engine_halted, flush_fifo_pulse, ptr_load;
  logic              clear_fifos_pulse, dma_flush_req;
  logic              seen_flush = 1'b0;
  logic [63:0]       exp_rd[$];
  logic [31:0]       exp_ptr[$];
  logic [63:0]       nt;
  int                n_mismatch = 0;
  int                checks_done = 0;
  int                cycles = 0;
  int                g, cnt;

  always #2 clk = ~clk;

  ishc_host_model u_ishc_host_model (.clk(clk), .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata));

  ishc_top u_ishc_top (.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .scsi_cond_in(scsi_cond_in),
    .dma_cond_in(dma_cond_in), .dma_fifo_empty(dma_fifo_empty), .dma_dir_write(dir_wr),
    .fetch_active(fetch_active), .fetch_fault(tie), .bus_cycle_active(tie), .reqack_busy(tie),
    .sync_offset_pending(tie), .xfer_ctrl_exec(xfer_ctrl_exec), .phase_jump(phase_jump),
    .jump_target(jump_target), .engine_start(engine_start), .irq_n(irq_n),
    .engine_halt_req(engine_halt_req), .engine_halted(engine_halted), .dma_flush_req(dma_flush_req),
    .clear_fifos_pulse(clear_fifos_pulse), .flush_fifo_pulse(flush_fifo_pulse), .ptr_load(ptr_load),
    .ptr_value(ptr_value));

  // ==========================================
  // Compare and report
  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic cmp1(input string nm, input logic e, input logic s);
    cmp32(nm, {31'h0, e}, {31'h0, s});
  endtask
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================
  // Result watchers, oldest note first
  always @(posedge clk) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      nt = exp_rd.pop_front();
      cmp32("readdata", nt[31:0], avs_readdata & nt[63:32]);
    end
    if (ptr_load === 1'b1) begin
      cmp32("ptr_value", exp_ptr.size() > 0 ? exp_ptr.pop_front() : ~ptr_value, ptr_value);
    end
    if (flush_fifo_pulse === 1'b1 && clear_fifos_pulse === 1'b1) seen_flush <= 1'b1;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ==========================================
  // Stimulus helpers
  task automatic rd(input logic [AW-1:0] a, input logic [3:0] be, input logic [31:0] e, input logic [31:0] m);
    exp_rd.push_back({m, e});
    u_ishc_host_model.xfer(1'b0, a, be, 32'h0);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    u_ishc_host_model.xfer(1'b1, a, 4'h3, d);
  endtask
  task automatic pulse(input logic [SW-1:0] s, input logic [DW-1:0] d);
    @(posedge clk);
    scsi_cond_in <= s;
    dma_cond_in <= d;
    @(posedge clk);
    scsi_cond_in <= '0;
    dma_cond_in <= '0;
    repeat (3) @(posedge clk);
  endtask
  task automatic restart;
    @(posedge clk);
    engine_start <= 1'b1;
    @(posedge clk);
    engine_start <= 1'b0;
  endtask
  task automatic pin(input string nm, input logic e, ref logic s);
    @(negedge clk);
    cmp1(nm, e, s);
  endtask

  // ==========================================
  // Scenarios
  initial begin
    void'($urandom(86420));
    g = 1 + ($urandom % 4);
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(REG_SUMMARY, 4'hf, 32'h0, '1);
    rd(REG_ENABLE, 4'hf, 32'h0, '1);
    rd(REG_CTRL, 4'hf, 32'h0800, '1);
    rd(5'h10, 4'hf, 32'h0, '1);
    wr(REG_CTRL, {16'h0, 8'(g), 8'h00});
    rd(REG_CTRL, 4'hf, {16'h0, 8'(g), 8'h00}, '1);
    wr(REG_ENABLE, 32'h7ffe);
    // Masked arbitration-done, then an enabled selection
    pulse(8'h01, 7'h00);
    rd(REG_SUMMARY, 4'hf, 32'h0, 32'h7);
    pin("irq_n", 1'b1, irq_n);
    pulse(8'h02, 7'h00);
    rd(REG_SUMMARY, 4'hf, 32'h5, 32'h7);
    // Two DMA events stack behind the SCSI one
    pulse(8'h00, 7'h01);
    pulse(8'h00, 7'h02);
    rd(REG_SUMMARY, 4'hf, 32'h5, 32'h7);
    wr(REG_ENABLE, 32'h0);
    pin("irq_n", 1'b0, irq_n);
    wr(REG_ENABLE, 32'h7ffe);
    rd(REG_STATUS, 4'h3, 32'h8003, '1);
    cnt = 0;
    @(negedge clk);
    while (irq_n === 1'b1 && cnt < 40) begin
      cnt++;
      @(negedge clk);
    end
    cmp1("gap", 1'b1, cnt >= g && cnt <= g + 2);
    rd(REG_SUMMARY, 4'hf, 32'h6, 32'h7);
    rd(REG_STATUS, 4'h3, 32'h8300, '1);
    restart();
    // Same-cycle SCSI and DMA events
    pulse(8'h10, 7'h04);
    rd(REG_SUMMARY, 4'hf, 32'h7, 32'h7);
    rd(REG_STATUS, 4'h3, 32'h8410, '1);
    repeat (g + 4) @(posedge clk);
    pin("irq_n", 1'b1, irq_n);
    restart();
    // SCSI held back behind a non-empty DMA FIFO
    dma_fifo_empty <= 1'b0;
    pulse(8'h00, 7'h04);
    pulse(8'h10, 7'h00);
    rd(REG_STATUS, 4'h3, 32'h0400, '1);
    repeat (g + 4) @(posedge clk);
    rd(REG_SUMMARY, 4'hf, 32'h0, 32'h1);
    wr(REG_CTRL, {16'h0, 8'(g), 8'h03});
    dma_fifo_empty <= 1'b1;
    @(posedge clk);
    pin("flush", 1'b1, seen_flush);
    repeat (3) @(posedge clk);
    rd(REG_STATUS, 4'h3, 32'h8010, '1);
    restart();
    // Masked fatal during a fetch and a transfer-control instruction
    wr(REG_ENABLE, 32'h77fe);
    fetch_active <= 1'b1;
    xfer_ctrl_exec <= 1'b1;
    phase_jump <= 1'b1;
    jump_target <= $urandom;
    pulse(8'h00, 7'h08);
    exp_ptr.push_back(jump_target);
    repeat (8) @(posedge clk);
    pin("halted", 1'b0, engine_halted);
    cmp1("halt_req", 1'b1, engine_halt_req);
    cmp1("irq_n", 1'b1, irq_n);
    @(posedge clk);
    fetch_active <= 1'b0;
    xfer_ctrl_exec <= 1'b0;
    for (cnt = 0; cnt < 30 && engine_halted !== 1'b1; cnt++) @(negedge clk);
    cmp1("halted", 1'b1, engine_halted);
    rd(REG_SUMMARY, 4'hf, 32'ha, 32'hf);
    rd(REG_STATUS, 4'h3, 32'h8800, '1);
    restart();
    // SCSI condition during a memory write waits for the FIFO to drain
    dir_wr <= 1'b1;
    phase_jump <= 1'b0;
    dma_fifo_empty <= 1'b0;
    pulse(8'h10, 7'h00);
    pin("flush_req", 1'b1, dma_flush_req);
    cmp1("halted", 1'b0, engine_halted);
    @(posedge clk);
    dma_fifo_empty <= 1'b1;
    repeat (3) @(posedge clk);
    pin("flush_req", 1'b0, dma_flush_req);
    cmp1("halted", 1'b1, engine_halted);
    repeat (4) @(posedge clk);
    cmp32("ptr_left", 32'h0, 32'(exp_ptr.size()));
    tally_and_finish();
  end
endmodule
